// ### core/fbc_pkg.sv
package fbc_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_WR_PULSE_NS = 50;
    localparam int T_RD_ACCESS_NS = 100;
    localparam int T_RESET_LOW_NS = 100;

    // least time rounded up to whole cycles, never below one
    function automatic int min_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : min_cyc

    localparam int WR_PULSE_CYC = min_cyc(T_WR_PULSE_NS);
    localparam int RD_ACCESS_CYC = min_cyc(T_RD_ACCESS_NS);
    localparam int RESET_LOW_CYC = min_cyc(T_RESET_LOW_NS);

    localparam int CNT_W = 8;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    typedef logic [CNT_W-1:0] fbc_cnt_t;

    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] ERASE_GO_CMD = 8'hD0;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] BYTE_PAD = 8'h00;

    // dq lanes the host drives; bit 15 is top_data_or_low_addr
    localparam logic [DATA_W-1:0] MASK_NONE = 16'h0000;
    localparam logic [DATA_W-1:0] MASK_ALL = 16'hFFFF;
    localparam logic [DATA_W-1:0] MASK_BYTE_WR = 16'h80FF;
    localparam logic [DATA_W-1:0] MASK_BYTE_RD = 16'h8000;
    localparam logic [DATA_W-1:0] OE_N_IDLE = 16'hFFFF;
    localparam logic [6:0] LANE_PAD = 7'h00;

    // only id_code_select may be high during an identification read
    localparam logic [ADDR_W-1:0] ID_CODE_SELECT_MASK = 17'h00001;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_ERASE = 3'h1,
        OP_PROGRAM = 3'h2,
        OP_READ_ARRAY = 3'h3,
        OP_ID_HV = 3'h4,
        OP_ID_CMD = 3'h5
    } fbc_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PRE = 3'h1,
        ST_FIRST = 3'h3,
        ST_SECOND = 3'h2,
        ST_DONE = 3'h6
    } fbc_state_t;

    typedef enum logic [1:0] {
        C_IDLE = 2'h0,
        C_SETUP = 2'h1,
        C_STROBE = 2'h3,
        C_HOLD = 2'h2
    } fbc_cstate_t;
endpackage : fbc_pkg

// ### core/fbc_cyc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fbc_cyc_if;
    logic start;
    logic wr;
    logic done;
    logic [15:0] wdata;
    logic [15:0] mask;
    logic [15:0] rdata;
    modport seq(output start, wr, wdata, mask, input done, rdata);
    modport cyc(input start, wr, wdata, mask, output done, rdata);
endinterface : fbc_cyc_if
`default_nettype wire

// ### core/fbc_cycle.sv
`timescale 1ns/1ps
`default_nettype none
module fbc_cycle #(
    parameter int WR_CYC = fbc_pkg::WR_PULSE_CYC,
    parameter int RD_CYC = fbc_pkg::RD_ACCESS_CYC
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    fbc_cyc_if.cyc bus,
    output logic chip_sel_n_o,
    output logic out_en_n_o,
    output logic write_n_o,
    output logic [15:0] dq_o,
    output logic [15:0] dq_oe_n_o,
    input wire logic [15:0] dq_i
);
    fbc_pkg::fbc_cstate_t st_r, st_nxt;
    fbc_pkg::fbc_cnt_t cnt_r;
    logic wr_r;
    logic cur_wr;
    logic [15:0] mask_r, cur_mask, data_r, cur_data;

    assign cur_wr = (st_r == fbc_pkg::C_IDLE) ? bus.wr : wr_r;
    assign cur_mask = (st_r == fbc_pkg::C_IDLE) ? bus.mask : mask_r;
    assign cur_data = (st_r == fbc_pkg::C_IDLE) ? bus.wdata : data_r;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            fbc_pkg::C_IDLE: if (bus.start) st_nxt = fbc_pkg::C_SETUP;
            fbc_pkg::C_SETUP: st_nxt = fbc_pkg::C_STROBE;
            fbc_pkg::C_STROBE: if (cnt_r == '0) st_nxt = fbc_pkg::C_HOLD;
            default: st_nxt = fbc_pkg::C_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_r <= fbc_pkg::C_IDLE;
            cnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            if (st_r == fbc_pkg::C_SETUP) begin
                cnt_r <= wr_r ? fbc_pkg::fbc_cnt_t'(WR_CYC - 1) : fbc_pkg::fbc_cnt_t'(RD_CYC - 1);
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            wr_r <= 1'b0;
            mask_r <= fbc_pkg::MASK_NONE;
            data_r <= '0;
        end else if (st_r == fbc_pkg::C_IDLE && bus.start) begin
            wr_r <= bus.wr;
            mask_r <= bus.mask;
            data_r <= bus.wdata;
        end
    end

    // pins follow the state they will be in, so they match st_r exactly
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            chip_sel_n_o <= 1'b1;
            out_en_n_o <= 1'b1;
            write_n_o <= 1'b1;
            dq_oe_n_o <= fbc_pkg::OE_N_IDLE;
            dq_o <= '0;
        end else begin
            chip_sel_n_o <= (st_nxt == fbc_pkg::C_IDLE);
            write_n_o <= !(st_nxt == fbc_pkg::C_STROBE && cur_wr);
            out_en_n_o <= !(st_nxt == fbc_pkg::C_STROBE && !cur_wr);
            dq_oe_n_o <= (st_nxt == fbc_pkg::C_IDLE) ? fbc_pkg::OE_N_IDLE : ~cur_mask;
            dq_o <= cur_data;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            bus.done <= 1'b0;
            bus.rdata <= '0;
        end else begin
            bus.done <= (st_r == fbc_pkg::C_HOLD);
            if (st_r == fbc_pkg::C_STROBE && cnt_r == '0 && !wr_r) bus.rdata <= dq_i;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    desel_float_a: assert property (chip_sel_n_o |-> (&dq_oe_n_o) && out_en_n_o
            && write_n_o)
        else $error("deselected but a strobe or data lane is active");
    write_strobe_a: assert property (!write_n_o |-> !chip_sel_n_o && out_en_n_o)
        else $error("write strobe without select or with output enable");
    setup_disable_a: assert property ($fell(chip_sel_n_o) |-> out_en_n_o && write_n_o)
        else $error("select fell together with a strobe");
    read_float_a: assert property (!out_en_n_o && !dq_oe_n_o[0] |-> 1'b0)
        else $error("host drives low data lane during a read");
endmodule : fbc_cycle
`default_nettype wire

// ### core/fbc_host.sv
// How it works
// - erase is setup code then confirm code, confirm directly after setup
// - program is setup code, then one write carrying address and data
// - after program, erase or command identify, write array-read code before reading
// - non-boot confirm and data write only with program supply raised
// - during high-voltage identify, other address lines held low
`timescale 1ns/1ps
`default_nettype none
module fbc_host #(
    parameter int ADDR_W = fbc_pkg::ADDR_W,
    parameter logic [7:0] ID_READ_CMD = 8'h00,
    parameter int RESET_LOW_CYC = fbc_pkg::RESET_LOW_CYC
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic req_valid_i,
    input wire logic [2:0] req_op_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic req_lsb_i,
    input wire logic [15:0] req_data_i,
    input wire logic req_boot_i,
    input wire logic req_word_i,
    input wire logic req_unlock_by_pin_i,
    input wire logic pd_req_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [15:0] rsp_data_o,
    output logic chip_sel_n_o,
    output logic out_en_n_o,
    output logic write_n_o,
    output logic reset_powerdown_n_o,
    output logic reset_unlock_hv_o,
    output logic boot_unlock_o,
    output logic program_supply_high_o,
    output logic id_voltage_addr_line_o,
    output logic word_width_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [15:0] dq_o,
    output logic [15:0] dq_oe_n_o,
    input wire logic [15:0] dq_i
);
    fbc_pkg::fbc_state_t st_r, st_nxt;
    fbc_pkg::fbc_op_t op_r, op_in, op_cur;
    fbc_pkg::fbc_cnt_t rst_cnt_r;
    logic [ADDR_W-1:0] addr_r, addr_cur;
    logic [15:0] data_r, data_cur;
    logic lsb_r, word_r, boot_r, pin_r, stale_r;
    logic lsb_cur, word_cur, boot_cur, pin_cur;
    logic go, cyc_wr, use_data, pd_idle, alters, last_step;
    logic [7:0] cyc_code, last_code_r;

    fbc_cyc_if bus();

    fbc_cycle u_cycle (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .bus(bus),
        .chip_sel_n_o(chip_sel_n_o),
        .out_en_n_o(out_en_n_o),
        .write_n_o(write_n_o),
        .dq_o(dq_o),
        .dq_oe_n_o(dq_oe_n_o),
        .dq_i(dq_i)
    );

    // byte width: data on low lanes, address bit on the top lane
    function automatic logic [15:0] bus_word(input logic [15:0] d, input logic lsb,
                                             input logic word);
        return word ? d : {lsb, fbc_pkg::LANE_PAD, d[7:0]};
    endfunction : bus_word

    function automatic logic [15:0] drive_mask(input logic wr, input logic word);
        if (wr) return word ? fbc_pkg::MASK_ALL : fbc_pkg::MASK_BYTE_WR;
        return word ? fbc_pkg::MASK_NONE : fbc_pkg::MASK_BYTE_RD;
    endfunction : drive_mask

    assign op_in = fbc_pkg::fbc_op_t'(req_op_i);
    assign op_cur = (st_r == fbc_pkg::ST_IDLE) ? op_in : op_r;
    assign addr_cur = (st_r == fbc_pkg::ST_IDLE) ? req_addr_i : addr_r;
    assign data_cur = (st_r == fbc_pkg::ST_IDLE) ? req_data_i : data_r;
    assign lsb_cur = (st_r == fbc_pkg::ST_IDLE) ? req_lsb_i : lsb_r;
    assign word_cur = (st_r == fbc_pkg::ST_IDLE) ? req_word_i : word_r;
    assign boot_cur = (st_r == fbc_pkg::ST_IDLE) ? req_boot_i : boot_r;
    assign pin_cur = (st_r == fbc_pkg::ST_IDLE) ? req_unlock_by_pin_i : pin_r;
    assign alters = (op_cur == fbc_pkg::OP_ERASE) || (op_cur == fbc_pkg::OP_PROGRAM);
    assign pd_idle = pd_req_i && (st_r == fbc_pkg::ST_IDLE) && !go;
    assign last_step = (st_nxt == fbc_pkg::ST_DONE) && (st_r != fbc_pkg::ST_DONE);

    always_comb begin
        st_nxt = st_r;
        go = 1'b0;
        case (st_r)
            fbc_pkg::ST_IDLE: begin
                if (req_valid_i && req_ready_o) begin
                    go = 1'b1;
                    st_nxt = (op_in == fbc_pkg::OP_READ && stale_r) ?
                             fbc_pkg::ST_PRE : fbc_pkg::ST_FIRST;
                end
            end
            fbc_pkg::ST_PRE: begin
                if (bus.done) begin
                    go = 1'b1;
                    st_nxt = fbc_pkg::ST_FIRST;
                end
            end
            fbc_pkg::ST_FIRST: begin
                if (bus.done) begin
                    if (alters || op_r == fbc_pkg::OP_ID_CMD) begin
                        go = 1'b1;
                        st_nxt = fbc_pkg::ST_SECOND;
                    end else begin
                        st_nxt = fbc_pkg::ST_DONE;
                    end
                end
            end
            fbc_pkg::ST_SECOND: if (bus.done) st_nxt = fbc_pkg::ST_DONE;
            default: st_nxt = fbc_pkg::ST_IDLE;
        endcase
        cyc_wr = 1'b1;
        use_data = 1'b0;
        cyc_code = fbc_pkg::CMD_READ_ARRAY;
        case (st_nxt)
            fbc_pkg::ST_FIRST: begin
                case (op_cur)
                    fbc_pkg::OP_READ, fbc_pkg::OP_ID_HV: cyc_wr = 1'b0;
                    fbc_pkg::OP_ERASE: cyc_code = fbc_pkg::CMD_ERASE_SETUP;
                    fbc_pkg::OP_PROGRAM: cyc_code = fbc_pkg::CMD_PROG_SETUP;
                    fbc_pkg::OP_ID_CMD: cyc_code = ID_READ_CMD;
                    default: cyc_code = fbc_pkg::CMD_READ_ARRAY;
                endcase
            end
            fbc_pkg::ST_SECOND: begin
                case (op_cur)
                    fbc_pkg::OP_ERASE: cyc_code = fbc_pkg::ERASE_GO_CMD;
                    fbc_pkg::OP_PROGRAM: use_data = 1'b1;
                    default: cyc_wr = 1'b0;
                endcase
            end
            default: cyc_code = fbc_pkg::CMD_READ_ARRAY;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_r <= fbc_pkg::ST_IDLE;
            op_r <= fbc_pkg::OP_READ;
            addr_r <= '0;
            data_r <= '0;
            lsb_r <= 1'b0;
            word_r <= 1'b0;
            boot_r <= 1'b0;
            pin_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (st_r == fbc_pkg::ST_IDLE && go) begin
                op_r <= op_in;
                addr_r <= req_addr_i;
                data_r <= req_data_i;
                lsb_r <= req_lsb_i;
                word_r <= req_word_i;
                boot_r <= req_boot_i;
                pin_r <= req_unlock_by_pin_i;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            bus.start <= 1'b0;
            bus.wr <= 1'b0;
            bus.wdata <= '0;
            bus.mask <= fbc_pkg::MASK_NONE;
            addr_o <= '0;
            word_width_o <= 1'b0;
            program_supply_high_o <= 1'b0;
            reset_unlock_hv_o <= 1'b0;
            boot_unlock_o <= 1'b0;
            id_voltage_addr_line_o <= 1'b0;
        end else begin
            bus.start <= go;
            if (go) begin
                bus.wr <= cyc_wr;
                bus.wdata <= bus_word(use_data ? data_cur : {fbc_pkg::BYTE_PAD, cyc_code},
                                      lsb_cur, word_cur);
                bus.mask <= drive_mask(cyc_wr, word_cur);
                word_width_o <= word_cur;
                if (op_cur == fbc_pkg::OP_ID_HV || op_cur == fbc_pkg::OP_ID_CMD) begin
                    addr_o <= addr_cur & ADDR_W'(fbc_pkg::ID_CODE_SELECT_MASK);
                end else begin
                    addr_o <= addr_cur;
                end
                program_supply_high_o <= (st_nxt == fbc_pkg::ST_SECOND) && alters;
                reset_unlock_hv_o <= (st_nxt == fbc_pkg::ST_SECOND) && alters && boot_cur
                                     && !pin_cur;
                boot_unlock_o <= (st_nxt == fbc_pkg::ST_SECOND) && alters && boot_cur
                                 && pin_cur;
                id_voltage_addr_line_o <= (st_nxt == fbc_pkg::ST_FIRST)
                                          && (op_cur == fbc_pkg::OP_ID_HV);
            end else if (st_nxt == fbc_pkg::ST_DONE) begin
                program_supply_high_o <= 1'b0;
                reset_unlock_hv_o <= 1'b0;
                boot_unlock_o <= 1'b0;
                id_voltage_addr_line_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            stale_r <= 1'b0;
        end else if (pd_idle || (st_r == fbc_pkg::ST_PRE && bus.done)) begin
            stale_r <= 1'b0;
        end else if (last_step) begin
            if (op_r == fbc_pkg::OP_READ_ARRAY) stale_r <= 1'b0;
            else if (op_r != fbc_pkg::OP_READ && op_r != fbc_pkg::OP_ID_HV) stale_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o <= '0;
        end else begin
            rsp_valid_o <= last_step;
            if (bus.done && !bus.wr) begin
                rsp_data_o <= word_r ? bus.rdata
                                     : {fbc_pkg::BYTE_PAD, bus.rdata[7:0]};
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rst_cnt_r <= fbc_pkg::fbc_cnt_t'(RESET_LOW_CYC);
            reset_powerdown_n_o <= 1'b0;
            req_ready_o <= 1'b0;
        end else begin
            if (pd_idle) rst_cnt_r <= fbc_pkg::fbc_cnt_t'(RESET_LOW_CYC);
            else if (rst_cnt_r != '0) rst_cnt_r <= rst_cnt_r - 1'b1;
            reset_powerdown_n_o <= !pd_idle && (rst_cnt_r == '0);
            req_ready_o <= !pd_idle && (rst_cnt_r == '0) && reset_powerdown_n_o
                           && (st_nxt == fbc_pkg::ST_IDLE);
        end
    end

    // helper: low byte of the last write put on the bus, command code or program data
    always_ff @(posedge core_clk_i) begin
        if (reset_i) last_code_r <= fbc_pkg::BYTE_PAD;
        else if (go && cyc_wr) last_code_r <= use_data ? data_cur[7:0] : cyc_code;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    // last_code_r already holds the second code when start rises, so look one cycle back
    erase_order_a: assert property (bus.start && st_r == fbc_pkg::ST_SECOND
            && op_r == fbc_pkg::OP_ERASE |-> $past(last_code_r) == fbc_pkg::CMD_ERASE_SETUP
            && bus.wdata[7:0] == fbc_pkg::ERASE_GO_CMD)
        else $error("erase_go_cmd not directly after erase setup");
    program_order_a: assert property (bus.start && st_r == fbc_pkg::ST_SECOND
            && op_r == fbc_pkg::OP_PROGRAM |-> $past(last_code_r) == fbc_pkg::CMD_PROG_SETUP
            && bus.wr)
        else $error("data write not directly after program setup");
    array_first_a: assert property (bus.start && !bus.wr && st_r == fbc_pkg::ST_FIRST
            && op_r == fbc_pkg::OP_READ |-> !stale_r)
        else $error("array read issued while array-read code is owed");
    supply_gate_a: assert property (!write_n_o && !program_supply_high_o |->
            !(st_r == fbc_pkg::ST_SECOND
            && (op_r == fbc_pkg::OP_ERASE || op_r == fbc_pkg::OP_PROGRAM)))
        else $error("confirm or data write without program supply");
    boot_unlock_a: assert property ($fell(write_n_o) && st_r == fbc_pkg::ST_SECOND && boot_r
            && op_r != fbc_pkg::OP_ID_CMD |-> (reset_unlock_hv_o || boot_unlock_o)
            && reset_powerdown_n_o)
        else $error("boot block altered without unlock");
    byte_lanes_a: assert property (!word_width_o && !chip_sel_n_o |->
            (&dq_oe_n_o[14:8]) && (dq_oe_n_o[15] == 1'b0))
        else $error("byte width drives lanes 8-14 or leaves top lane");
    id_addr_low_a: assert property (id_voltage_addr_line_o |->
            (addr_o & ~ADDR_W'(fbc_pkg::ID_CODE_SELECT_MASK)) == '0 && !program_supply_high_o)
        else $error("address lines not low during identify");
    reset_hold_a: assert property ($rose(reset_powerdown_n_o) |-> $past(rst_cnt_r) == '0
            && st_r == fbc_pkg::ST_IDLE)
        else $error("reset pin released early");
    hv_id_read_a: assert property (id_voltage_addr_line_o && !chip_sel_n_o |-> write_n_o)
        else $error("write during high-voltage identify");
endmodule : fbc_host
`default_nettype wire

// ### verification/fbc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model #(
    parameter logic [16:0] BOOT_LO = 17'h1E000,
    parameter logic [7:0] ID_CMD = 8'h55,
    parameter logic [7:0] MFR_CODE = 8'hA5, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h3C, // arbitrary value
    parameter logic [7:0] ID_HI = 8'h5A // arbitrary value
) (
    input wire logic reset_powerdown_n_i,
    input wire logic reset_unlock_hv_i,
    input wire logic boot_unlock_i,
    input wire logic program_supply_high_i,
    input wire logic id_voltage_addr_line_i,
    input wire logic word_width_i,
    input wire logic chip_sel_n_i,
    input wire logic out_en_n_i,
    input wire logic write_n_i,
    input wire logic [16:0] addr_i,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic [15:0] dq_en_o
);
    logic [15:0] mem [logic [16:0]];
    logic [15:0] w;
    logic [15:0] rdw;
    logic ok;
    logic id;
    int st = 0;

    function automatic logic [15:0] rd(input logic [16:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction : rd

    assign ok = program_supply_high_i
        && (addr_i < BOOT_LO || reset_unlock_hv_i || boot_unlock_i);

    // status mode (st 4) reads back a busy-free status, not array data
    always @(posedge write_n_i) begin
        if (reset_powerdown_n_i && !chip_sel_n_i && out_en_n_i) begin
            if (st == 2) begin
                if (dq_i[7:0] == 8'hD0 && ok) begin
                    foreach (mem[k]) if (k[16:13] == addr_i[16:13]) mem[k] = 16'hFFFF;
                end
                st = 4;
            end else if (st == 3) begin
                w = rd(addr_i);
                if (word_width_i) w = dq_i;
                else if (dq_i[15]) w[15:8] = dq_i[7:0];
                else w[7:0] = dq_i[7:0];
                if (ok) mem[addr_i] = w;
                st = 4;
            end else begin
                case (dq_i[7:0])
                    8'h20: st = 2;
                    8'h10, 8'h40: st = 3;
                    8'hFF: st = 0;
                    ID_CMD: st = 1;
                    default: ;
                endcase
            end
        end
    end

    always @(negedge reset_powerdown_n_i) st = 0;

    always @* begin
        id = (st == 1) || id_voltage_addr_line_i;
        rdw = id ? {ID_HI, addr_i[0] ? DEV_CODE : MFR_CODE}
                 : (st == 0 ? rd(addr_i) : 16'h0080);
        dq_o = word_width_i ? rdw : {8'h00, (dq_i[15] && !id) ? rdw[15:8] : rdw[7:0]};
        dq_en_o = 16'h0000;
        if (reset_powerdown_n_i && !chip_sel_n_i && !out_en_n_i && write_n_i)
            dq_en_o = word_width_i ? 16'hFFFF : 16'h00FF;
    end
endmodule : fbc_flash_model
`default_nettype wire

// ### verification/flash_bus_command_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
module flash_bus_command_decode_test;
    localparam logic [7:0] MFR = 8'hA5; // arbitrary value
    localparam logic [7:0] DEV = 8'h3C; // arbitrary value
    localparam logic [7:0] HI = 8'h5A; // arbitrary value
    localparam logic [16:0] BOOT = 17'h1E000;
    logic core_clk_i = 0, reset_i = 1, req_valid_i = 0, req_lsb_i = 0, req_boot_i = 0;
    logic req_word_i = 1, req_unlock_by_pin_i = 0, pd_req_i = 0, tog = 0, rq;
    logic [2:0] req_op_i = 0;
    logic [16:0] req_addr_i = 0, a, addr_o;
    logic [15:0] req_data_i = 0, rsp_data_o, dq_o, dq_oe_n_o, dq_bus, dev_dq, dev_en, d, ev;
    logic req_ready_o, rsp_valid_o, chip_sel_n_o, out_en_n_o, write_n_o, reset_powerdown_n_o;
    logic reset_unlock_hv_o, boot_unlock_o, program_supply_high_o, id_voltage_addr_line_o;
    logic word_width_o;
    logic [31:0] rs = 62, r;
    bit q_rd[$];
    logic [15:0] q_v[$];
    int n_fail = 0, num_checks = 0, i, k;

    always #12.5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) tog <= ~tog;
    // undriven lanes wander so a stale value never reads as valid
    assign dq_bus = (~dq_oe_n_o & dq_o) | (dq_oe_n_o & dev_en & dev_dq)
        | (dq_oe_n_o & ~dev_en & (16'h5555 ^ {16{tog}}));

    fbc_host #(.ID_READ_CMD(8'h55), .RESET_LOW_CYC(1)) dut_u (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
        .req_addr_i(req_addr_i), .req_lsb_i(req_lsb_i), .req_data_i(req_data_i),
        .req_boot_i(req_boot_i), .req_word_i(req_word_i),
        .req_unlock_by_pin_i(req_unlock_by_pin_i), .pd_req_i(pd_req_i),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
        .chip_sel_n_o(chip_sel_n_o), .out_en_n_o(out_en_n_o), .write_n_o(write_n_o),
        .reset_powerdown_n_o(reset_powerdown_n_o), .reset_unlock_hv_o(reset_unlock_hv_o),
        .boot_unlock_o(boot_unlock_o), .program_supply_high_o(program_supply_high_o),
        .id_voltage_addr_line_o(id_voltage_addr_line_o), .word_width_o(word_width_o),
        .addr_o(addr_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .dq_i(dq_bus));

    fbc_flash_model #(.BOOT_LO(BOOT), .ID_CMD(8'h55), .MFR_CODE(MFR), .DEV_CODE(DEV),
        .ID_HI(HI)) mdl_u (.reset_powerdown_n_i(reset_powerdown_n_o),
        .reset_unlock_hv_i(reset_unlock_hv_o), .boot_unlock_i(boot_unlock_o),
        .program_supply_high_i(program_supply_high_o),
        .id_voltage_addr_line_i(id_voltage_addr_line_o), .word_width_i(word_width_o),
        .chip_sel_n_i(chip_sel_n_o), .out_en_n_i(out_en_n_o), .write_n_i(write_n_o),
        .addr_i(addr_o), .dq_i(dq_bus), .dq_o(dev_dq), .dq_en_o(dev_en));

    function logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs

    task wrap_up();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task tmo();
        n_fail++;
        $display("[FAIL] %0t wait ran out", $time);
        wrap_up();
    endtask : tmo

    // op, address, byte lsb, data, boot, word, unlock by pin, is read, expected
    task req(input logic [2:0] op, input logic [16:0] ad, input logic l, input logic [15:0] dt,
             input logic bt, input logic wd, input logic pn, input bit rd, input logic [15:0] ex);
        int n;
        @(posedge core_clk_i);
        req_valid_i <= 1;
        req_op_i <= op;
        req_addr_i <= ad;
        req_lsb_i <= l;
        req_data_i <= dt;
        req_boot_i <= bt;
        req_word_i <= wd;
        req_unlock_by_pin_i <= pn;
        n = 0;
        @(negedge core_clk_i);
        while (req_ready_o !== 1'b1 && n < 300) begin
            @(negedge core_clk_i);
            n++;
        end
        if (n >= 300) tmo();
        q_rd.push_back(rd);
        q_v.push_back(ex);
        @(posedge core_clk_i);
        req_valid_i <= 0;
    endtask : req

    always @(negedge core_clk_i) begin
        if (!reset_i && rsp_valid_o === 1'b1) begin
            if (q_rd.size() == 0) tmo();
            rq = q_rd.pop_front();
            ev = q_v.pop_front();
            if (rq) check(rsp_data_o, ev);
        end
    end

    initial begin
        repeat (10) @(posedge core_clk_i);
        reset_i <= 0;
        for (k = 0; k < 4; k++) begin
            r = xs();
            a = {1'b0, r[15:0]};
            d = r[31:16];
            req(3'h2, a, 0, d, 0, 1, 0, 0, 0);
            req(3'h0, a, 0, 0, 0, 1, 0, 1, d);
        end
        r = xs();
        a = {1'b0, r[15:0]};
        req(3'h2, a, 0, {8'h00, r[23:16]}, 0, 0, 0, 0, 0);
        req(3'h2, a, 1, {8'h00, r[31:24]}, 0, 0, 0, 0, 0);
        req(3'h0, a, 1, 0, 0, 0, 0, 1, {8'h00, r[31:24]});
        req(3'h0, a, 0, 0, 0, 0, 0, 1, {8'h00, r[23:16]});
        req(3'h0, a, 0, 0, 0, 1, 0, 1, r[31:16]);
        req(3'h1, a, 0, 0, 0, 1, 0, 0, 0);
        req(3'h0, a, 0, 0, 0, 1, 0, 1, 16'hFFFF);
        for (k = 0; k < 2; k++) begin
            r = xs();
            a = BOOT + {4'h0, r[12:0]};
            req(3'h2, a, 0, r[31:16], 1, 1, k[0], 0, 0);
            req(3'h0, a, 0, 0, 1, 1, k[0], 1, r[31:16]);
        end
        for (k = 0; k < 8; k++) begin
            d = {8'h00, k[0] ? DEV : MFR};
            if (k[1]) d[15:8] = HI;
            req(k[2] ? 3'h5 : 3'h4, {16'h0000, k[0]}, 0, 0, 0, k[1], 0, 1, d);
        end
        @(posedge core_clk_i);
        pd_req_i <= 1;
        // last identify still runs about 15 cycles before power-down can start
        repeat (30) @(negedge core_clk_i);
        check({15'h0000, reset_powerdown_n_o}, 16'h0000);
        check({15'h0000, req_ready_o}, 16'h0000);
        @(posedge core_clk_i);
        pd_req_i <= 0;
        req(3'h3, 0, 0, 0, 0, 1, 0, 0, 0);
        req(3'h0, a, 0, 0, 1, 1, 0, 1, r[31:16]);
        i = 0;
        while (q_rd.size() > 0 && i < 500) begin
            @(posedge core_clk_i);
            i++;
        end
        if (i >= 500) tmo();
        wrap_up();
    end
endmodule : flash_bus_command_decode_test
`default_nettype wire
